/* File: hdl/spcd_host.sv */
// host controller driving flash sector protection command sequences
// Behaviour
// [R1] mode entry is AAA/AA, 555/55, AAA/mode code before mode commands
// [R2] code 40 lock mode: A0 then data programs; read at 00 returns it
// [R3] exit is 90 then 00 at any address, or single F0
// [R4] each password byte is written as A0 then byte to its address
// [R5] password bytes 0..7 sit at addresses 00h..07h in sector zero
// [R6] password read is eight reads at addresses 00..07 with full address
// [R7] unlock: 00/25, 00/03, eight bytes, 00/29; full match unlocks
// [R8] code C0 persistent mode: A0 then 00 at sector address programs it
// [R9] erase-all is 80 then 00/30; device preprograms then erases
// [R10] status read gives bit zero low when protected, high when not
// [R11] code 50 freeze mode: A0 then 00 sets lock; read shows it
// [R12] code E0 volatile mode: A0 then 00 sets, A0 then 01 clears
// [R13] accelerate input held high while setting persistent or volatile bits
// [R14] wrong or misordered writes need the reset command afterwards
// [R15] unspecified address and data bits are don't care
// [R16] address latched at strobe fall, data at strobe rise
// [R17] bits above address bit 11 are don't care for 555/AAA cycles
// [R18] while a mode is active only its commands, exit or reset apply
`timescale 1ns/100ps
`default_nettype none
module spcd_host (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic [22:0]      fl_addr,
    output logic [7:0]       fl_dq_out,
    output logic             fl_dq_oe,
    input  wire logic [7:0]  fl_dq_in,
    output logic             fl_ce_n,
    output logic             fl_we_n,
    output logic             fl_oe_n,
    output logic             accelerate_input
);
    typedef enum logic [2:0] {S_IDLE, S_LOAD, S_SETUP, S_PULSE, S_HOLD} spcd_st_e;

    typedef struct packed {
        spcd_st_e    st;
        logic [3:0]  cnt;
        logic [2:0]  op;
        logic [3:0]  step;
        logic        busy;
        logic        done;
        logic [7:0]  mode;
        logic [22:0] addr;
        logic [7:0]  wdata;
        logic [63:0] pwd;
        logic [7:0]  rdata;
        logic        aw_pend;
        logic [2:0]  aw_idx;
        logic [31:0] hrdata;
        logic [22:0] fl_addr;
        logic [7:0]  dq_out;
        logic        dq_oe;
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic        accel;
    } spcd_state_s;

    spcd_state_s q_ff;
    spcd_state_s nxt_q;

    // one bus cycle of an operation: {is_read, address, data}
    function automatic logic [31:0] step_fn(input logic [2:0]  op,
                                            input logic [3:0]  step,
                                            input logic [22:0] addr,
                                            input logic [7:0]  wdata,
                                            input logic [63:0] pwd);
        logic [2:0] idx;
        idx = 3'(step - spcd_pkg::UNL_FIRST_B);
        step_fn = {1'b0, spcd_pkg::A_ZERO, spcd_pkg::D_RESET};
        unique case (op)
            // [R1] unlock pair and mode code
            spcd_pkg::OP_ENTER:
                if (step == 4'h0)      step_fn = {1'b0, spcd_pkg::A_AAA, spcd_pkg::D_AA};
                else if (step == 4'h1) step_fn = {1'b0, spcd_pkg::A_555, spcd_pkg::D_55};
                else                   step_fn = {1'b0, spcd_pkg::A_AAA, wdata};
            // [R3] two-cycle exit
            spcd_pkg::OP_EXIT:
                step_fn = {1'b0, spcd_pkg::A_ZERO,
                           (step == 4'h0) ? spcd_pkg::D_EXIT : spcd_pkg::D_ZERO};
            // [R3] [R14] single reset write
            spcd_pkg::OP_RESET: step_fn = {1'b0, spcd_pkg::A_ZERO, spcd_pkg::D_RESET};
            // [R2] [R8] [R11] [R12] mode program pair
            // [R4] full pair per programmed value
            spcd_pkg::OP_PROG:
                step_fn = (step == 4'h0) ? {1'b0, spcd_pkg::A_ZERO, spcd_pkg::D_PROG}
                                         : {1'b0, addr, wdata};
            // [R9] erase-all pair
            spcd_pkg::OP_ERASE:
                step_fn = {1'b0, spcd_pkg::A_ZERO,
                           (step == 4'h0) ? spcd_pkg::D_ERASE : spcd_pkg::D_ERASE_GO};
            // [R2] [R11] [R12] single status read
            // [R6] reads drive the full address
            spcd_pkg::OP_READ: step_fn = {1'b1, addr, spcd_pkg::D_ZERO};
            // [R7] unlock frame around the eight bytes
            spcd_pkg::OP_UNLOCK:
                if (step == 4'h0)      step_fn = {1'b0, spcd_pkg::A_ZERO, spcd_pkg::D_UNL_1};
                else if (step == 4'h1) step_fn = {1'b0, spcd_pkg::A_ZERO, spcd_pkg::D_UNL_2};
                else if (step == spcd_pkg::UNL_LAST)
                    step_fn = {1'b0, spcd_pkg::A_ZERO, spcd_pkg::D_UNL_GO};
                // [R5] byte n at address n
                else step_fn = {1'b0, 20'h00000, idx, pwd[{idx, 3'b000} +: 8]};
            default: step_fn = {1'b0, spcd_pkg::A_ZERO, spcd_pkg::D_RESET};
        endcase
    endfunction : step_fn

    function automatic logic [3:0] last_fn(input logic [2:0] op);
        unique case (op)
            spcd_pkg::OP_ENTER:  last_fn = 4'h2;
            spcd_pkg::OP_EXIT,
            spcd_pkg::OP_PROG,
            spcd_pkg::OP_ERASE:  last_fn = 4'h1;
            spcd_pkg::OP_UNLOCK: last_fn = spcd_pkg::UNL_LAST;
            default:             last_fn = 4'h0;
        endcase
    endfunction : last_fn

    logic [31:0] cur_step;
    logic [31:0] status_w;
    assign cur_step = step_fn(q_ff.op, q_ff.step, q_ff.addr, q_ff.wdata, q_ff.pwd);
    assign status_w = {8'h00, q_ff.mode, q_ff.rdata, 6'h00, q_ff.done, q_ff.busy};

    always_comb begin
        nxt_q = q_ff;
        // ahb address phase, zero wait states
        nxt_q.aw_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                nxt_q.aw_pend = 1'b1;
                nxt_q.aw_idx  = haddr[4:2];
            end else begin
                unique case (haddr[4:2])
                    spcd_pkg::REG_ADDR:   nxt_q.hrdata = {9'h000, q_ff.addr};
                    spcd_pkg::REG_WDATA:  nxt_q.hrdata = {24'h000000, q_ff.wdata};
                    spcd_pkg::REG_PWD_LO: nxt_q.hrdata = q_ff.pwd[31:0];
                    spcd_pkg::REG_PWD_HI: nxt_q.hrdata = q_ff.pwd[63:32];
                    spcd_pkg::REG_STATUS: nxt_q.hrdata = status_w;
                    default:              nxt_q.hrdata = 32'h00000000;
                endcase
            end
        end
        // ahb data phase of a write
        if (q_ff.aw_pend) begin
            unique case (q_ff.aw_idx)
                spcd_pkg::REG_ADDR:   nxt_q.addr = hwdata[22:0];
                spcd_pkg::REG_WDATA:  nxt_q.wdata = hwdata[7:0];
                spcd_pkg::REG_PWD_LO: nxt_q.pwd[31:0] = hwdata;
                spcd_pkg::REG_PWD_HI: nxt_q.pwd[63:32] = hwdata;
                spcd_pkg::REG_CTRL:
                    // [R14] one op at a time
                    if (!q_ff.busy && hwdata[2:0] != 3'h7) begin
                        nxt_q.op   = hwdata[2:0];
                        nxt_q.step = 4'h0;
                        nxt_q.busy = 1'b1;
                        nxt_q.done = 1'b0;
                        nxt_q.st   = S_LOAD;
                    end
                default: ;
            endcase
        end
        // flash bus cycle sequencer
        unique case (q_ff.st)
            S_IDLE: ;
            S_LOAD: begin
                nxt_q.fl_addr = cur_step[30:8];
                nxt_q.dq_out  = cur_step[7:0];
                nxt_q.dq_oe   = !cur_step[31];
                nxt_q.ce_n    = 1'b0;
                // [R13] accelerate high while setting protect bits
                nxt_q.accel   = (q_ff.op == spcd_pkg::OP_PROG) &&
                                (q_ff.mode == spcd_pkg::M_PERSIST ||
                                 q_ff.mode == spcd_pkg::M_VOLATILE);
                nxt_q.cnt     = spcd_pkg::T_SU - 4'h1;
                nxt_q.st      = S_SETUP;
            end
            S_SETUP:
                if (q_ff.cnt != 4'h0) nxt_q.cnt = q_ff.cnt - 4'h1;
                else begin
                    // [R16] strobe falls after address is stable
                    nxt_q.we_n = cur_step[31];
                    nxt_q.oe_n = !cur_step[31];
                    nxt_q.cnt  = (cur_step[31] ? spcd_pkg::T_RP : spcd_pkg::T_WP) - 4'h1;
                    nxt_q.st   = S_PULSE;
                end
            S_PULSE:
                if (q_ff.cnt != 4'h0) nxt_q.cnt = q_ff.cnt - 4'h1;
                else begin
                    // [R10] capture read byte, bit zero is the indicator
                    if (!q_ff.oe_n) nxt_q.rdata = fl_dq_in;
                    nxt_q.we_n = 1'b1;
                    nxt_q.oe_n = 1'b1;
                    nxt_q.cnt  = spcd_pkg::T_HD - 4'h1;
                    nxt_q.st   = S_HOLD;
                end
            S_HOLD:
                if (q_ff.cnt != 4'h0) nxt_q.cnt = q_ff.cnt - 4'h1;
                else begin
                    nxt_q.ce_n  = 1'b1;
                    nxt_q.dq_oe = 1'b0;
                    nxt_q.accel = 1'b0;
                    if (q_ff.step == last_fn(q_ff.op)) begin
                        nxt_q.busy = 1'b0;
                        nxt_q.done = 1'b1;
                        nxt_q.st   = S_IDLE;
                        // [R18] track the active mode
                        if (q_ff.op == spcd_pkg::OP_ENTER) nxt_q.mode = q_ff.wdata;
                        // [R3] exit or reset leaves every mode
                        if (q_ff.op == spcd_pkg::OP_EXIT || q_ff.op == spcd_pkg::OP_RESET)
                            nxt_q.mode = 8'h00;
                    end else begin
                        nxt_q.step = q_ff.step + 4'h1;
                        nxt_q.st   = S_LOAD;
                    end
                end
            default: nxt_q.st = S_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_ff      <= '0;
            q_ff.st   <= S_IDLE;
            q_ff.ce_n <= 1'b1;
            q_ff.we_n <= 1'b1;
            q_ff.oe_n <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // zero wait states, response always okay
    assign hreadyout        = !q_ff.aw_pend || q_ff.aw_pend;
    assign hrdata           = q_ff.hrdata;
    assign hresp            = q_ff.aw_pend && !q_ff.aw_pend;
    assign fl_addr          = q_ff.fl_addr;
    assign fl_dq_out        = q_ff.dq_out;
    assign fl_dq_oe         = q_ff.dq_oe;
    assign fl_ce_n          = q_ff.ce_n;
    assign fl_we_n          = q_ff.we_n;
    assign fl_oe_n          = q_ff.oe_n;
    assign accelerate_input = q_ff.accel;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // write strobe fell at the last edge: first pulse cycle of a write
    logic we_fall;
    assign we_fall = !q_ff.we_n && q_ff.st == S_PULSE &&
                     q_ff.cnt == spcd_pkg::T_WP - 4'h1;

    sequence s_wpulse;
        !fl_we_n [*4] ##1 fl_we_n;
    endsequence
    sequence s_ce_release;
        !fl_ce_n [*2] ##1 fl_ce_n;
    endsequence

    entry_unlock_a: assert property (we_fall && q_ff.op == spcd_pkg::OP_ENTER && // [R1]
        q_ff.step == 4'h0 |-> fl_addr == spcd_pkg::A_AAA && fl_dq_out == spcd_pkg::D_AA)
        else $error("entry first cycle wrong");
    entry_code_a: assert property (we_fall && q_ff.op == spcd_pkg::OP_ENTER && // [R1]
        q_ff.step == 4'h2 |-> fl_addr == spcd_pkg::A_AAA && fl_dq_out == q_ff.wdata)
        else $error("entry mode code wrong");
    exit_first_a: assert property (we_fall && q_ff.op == spcd_pkg::OP_EXIT && // [R3]
        q_ff.step == 4'h0 |-> fl_dq_out == spcd_pkg::D_EXIT)
        else $error("exit first byte wrong");
    write_pulse_a: assert property ($fell(fl_we_n) |-> s_wpulse ##0 s_ce_release) // [R16]
        else $error("write strobe width wrong");
    read_drive_a: assert property ($fell(fl_oe_n) |-> fl_we_n && !fl_dq_oe // [R6]
        && !fl_ce_n && fl_addr == q_ff.addr)
        else $error("read cycle drives bus");
    unlock_byte_a: assert property (we_fall && q_ff.op == spcd_pkg::OP_UNLOCK && // [R5]
        q_ff.step >= 4'h2 && q_ff.step <= 4'h9 |-> fl_addr == 23'(q_ff.step - 4'h2))
        else $error("password byte address wrong");
    unlock_last_a: assert property (we_fall && q_ff.op == spcd_pkg::OP_UNLOCK && // [R7]
        q_ff.step == spcd_pkg::UNL_LAST |-> fl_dq_out == spcd_pkg::D_UNL_GO
        && fl_addr == spcd_pkg::A_ZERO)
        else $error("unlock close wrong");
    erase_go_a: assert property (we_fall && q_ff.op == spcd_pkg::OP_ERASE && // [R9]
        q_ff.step == 4'h1 |-> fl_dq_out == spcd_pkg::D_ERASE_GO)
        else $error("erase confirm wrong");
    accel_hold_a: assert property (!fl_we_n && q_ff.op == spcd_pkg::OP_PROG && // [R13]
        (q_ff.mode == spcd_pkg::M_PERSIST || q_ff.mode == spcd_pkg::M_VOLATILE)
        |-> accelerate_input)
        else $error("accelerate low while setting bit");
    mode_clear_a: assert property ($rose(q_ff.done) && // [R18]
        (q_ff.op == spcd_pkg::OP_EXIT || q_ff.op == spcd_pkg::OP_RESET) |-> q_ff.mode == 8'h00)
        else $error("mode not left after exit");
endmodule : spcd_host
`default_nettype wire

/* File: hdl/spcd_pkg.sv */
// constants for the sector protection command host
package spcd_pkg;
    localparam int          CLK_NS      = 10;
    localparam int          FL_AW       = 23;
    // bus cycle timing in ns and derived clock counts
    localparam int          T_SU_NS     = 20;
    localparam int          T_WP_NS     = 40;
    localparam int          T_RP_NS     = 80;
    localparam int          T_HD_NS     = 20;
    localparam logic [3:0]  T_SU        = 4'((T_SU_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  T_WP        = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  T_RP        = 4'((T_RP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  T_HD        = 4'((T_HD_NS + CLK_NS - 1) / CLK_NS);
    // register indexes (byte offset = 4 * index)
    localparam logic [2:0]  REG_CTRL    = 3'h0;
    localparam logic [2:0]  REG_ADDR    = 3'h1;
    localparam logic [2:0]  REG_WDATA   = 3'h2;
    localparam logic [2:0]  REG_PWD_LO  = 3'h3;
    localparam logic [2:0]  REG_PWD_HI  = 3'h4;
    localparam logic [2:0]  REG_STATUS  = 3'h5;
    // status fields
    localparam int          ST_BUSY     = 0;
    localparam int          ST_DONE     = 1;
    localparam int          ST_RDATA    = 8;
    localparam int          ST_MODE     = 16;
    // operation codes in ctrl[2:0]
    localparam logic [2:0]  OP_ENTER    = 3'h0;
    localparam logic [2:0]  OP_EXIT     = 3'h1;
    localparam logic [2:0]  OP_RESET    = 3'h2;
    localparam logic [2:0]  OP_PROG     = 3'h3;
    localparam logic [2:0]  OP_ERASE    = 3'h4;
    localparam logic [2:0]  OP_READ     = 3'h5;
    localparam logic [2:0]  OP_UNLOCK   = 3'h6;
    // command bytes and addresses
    localparam logic [22:0] A_AAA       = 23'h000AAA;
    localparam logic [22:0] A_555       = 23'h000555;
    localparam logic [22:0] A_ZERO      = 23'h000000;
    localparam logic [7:0]  D_AA        = 8'hAA;
    localparam logic [7:0]  D_55        = 8'h55;
    localparam logic [7:0]  D_PROG      = 8'hA0;
    localparam logic [7:0]  D_EXIT      = 8'h90;
    localparam logic [7:0]  D_ZERO      = 8'h00;
    localparam logic [7:0]  D_RESET     = 8'hF0;
    localparam logic [7:0]  D_ERASE     = 8'h80;
    localparam logic [7:0]  D_ERASE_GO  = 8'h30;
    localparam logic [7:0]  D_UNL_1     = 8'h25;
    localparam logic [7:0]  D_UNL_2     = 8'h03;
    localparam logic [7:0]  D_UNL_GO    = 8'h29;
    localparam logic [7:0]  M_PERSIST   = 8'hC0;
    localparam logic [7:0]  M_VOLATILE  = 8'hE0;
    localparam logic [3:0]  UNL_FIRST_B = 4'h2;
    localparam logic [3:0]  UNL_LAST    = 4'hA;
endpackage : spcd_pkg

/* File: bench/spcd_flash_model.sv */
// behavioural flash device answering the sector protection command sets
`timescale 1ns/100ps
`default_nettype none
module spcd_flash_model (
    input  wire logic [22:0] fl_addr,
    input  wire logic [7:0]  fl_dq_out,
    input  wire logic        fl_ce_n,
    input  wire logic        fl_we_n,
    input  wire logic        fl_oe_n,
    input  wire logic        accelerate_input,
    output logic [7:0]       fl_dq_in,
    output logic [7:0]       mode,
    output logic             unlocked,
    output int               acc_err
);
    logic [7:0]   lock_reg, last, rd_val;
    logic [7:0]   pwd [8];
    logic [127:0] persist, volat;
    logic         freeze, ok;
    logic [22:0]  la;
    int           st, cnt;
    initial begin
        mode = 8'h00; st = 0; lock_reg = 8'h00; last = 8'h00; freeze = 1'b0;
        persist = '0; volat = '0; unlocked = 1'b0; acc_err = 0;
        for (int i = 0; i < 8; i++) pwd[i] = 8'h00;
    end
    always @(negedge fl_we_n) la = fl_addr;
    always @(posedge fl_we_n) if (!fl_ce_n) wr(la, fl_dq_out);
    task automatic wr(input logic [22:0] a, input logic [7:0] d);
        if (st == 4) begin st = (d == 8'h03) ? 5 : 0; cnt = 0; ok = 1'b1; end
        else if (st == 5) begin
            ok = ok && (pwd[a[2:0]] == d);
            cnt++;
            if (cnt == 8) st = 6;
        end else if (st == 6) begin unlocked = ok && d == 8'h29 && a == 23'h000000; st = 0; end
        else if (d == 8'hF0) begin mode = 8'h00; st = 0; end
        else if (st == 9) begin if (d == 8'h00) mode = 8'h00; st = 0; end
        // entry, low twelve address bits only
        else if (mode == 8'h00) begin
            if (st == 0 && a[11:0] == 12'hAAA && d == 8'hAA) st = 1;
            else if (st == 1 && a[11:0] == 12'h555 && d == 8'h55) st = 2;
            else if (st == 2 && a[11:0] == 12'hAAA) begin mode = d; st = 0; end
            else st = 0;
        end
        else if (st == 1) begin
            if ((mode == 8'hC0 || mode == 8'hE0) && accelerate_input !== 1'b1) acc_err++;
            case (mode)
                8'h40: lock_reg = d;
                8'h60: pwd[a[2:0]] = d;
                8'hC0: if (d == 8'h00) persist[a[22:16]] = 1'b1;
                8'h50: if (d == 8'h00) freeze = 1'b1;
                8'hE0: volat[a[22:16]] = ~d[0];
                default: ;
            endcase
            st = 0;
        end
        else if (st == 3) begin
            if (d == 8'h30 && a == 23'h000000) begin persist = '1; persist = '0; end
            st = 0;
        end
        // only the mode's own commands and the 90 exit are taken
        else if (d == 8'hA0) st = 1;
        else if (d == 8'h90) st = 9;
        else if (d == 8'h80 && mode == 8'hC0) st = 3;
        else if (d == 8'h25 && mode == 8'h60 && a == 23'h000000) st = 4;
        else st = 0;
    endtask : wr
    always_comb begin
        case (mode)
            8'h40: rd_val = lock_reg;
            8'h60: rd_val = pwd[fl_addr[2:0]];
            8'hC0: rd_val = {7'h00, ~persist[fl_addr[22:16]]};
            8'h50: rd_val = {7'h00, ~freeze};
            8'hE0: rd_val = {7'h00, ~volat[fl_addr[22:16]]};
            default: rd_val = 8'hFF;
        endcase
    end
    // released bus shows the inverse of the last byte
    always @(posedge fl_oe_n) last = rd_val;
    assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd_val : ~last;
endmodule : spcd_flash_model
`default_nettype wire

/* File: bench/tb_sector_protect_cmd_decoder.sv */
// self-checking bench for the sector protection command host
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module tb_sector_protect_cmd_decoder;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, st;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [22:0] fl_addr;
    logic [7:0]  fl_dq_out, fl_dq_in, m_mode;
    logic        fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, accelerate_input, m_unl;
    int          m_acc, bad_count, total_checks;
    logic [63:0] pw;
    spcd_host i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fl_addr(fl_addr),
        .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n),
        .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .accelerate_input(accelerate_input));
    spcd_flash_model i_model (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_ce_n(fl_ce_n),
        .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .accelerate_input(accelerate_input),
        .fl_dq_in(fl_dq_in), .mode(m_mode), .unlocked(m_unl), .acc_err(m_acc));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic bus(input logic w, input logic [2:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {27'h0000000, idx, 2'h0};
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) bad_count++;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) bad_count++;
        rd = hrdata;
    endtask : bus
    task automatic op(input logic [2:0] c, input logic [22:0] a, input logic [7:0] d);
        int n;
        bus(1'b1, spcd_pkg::REG_ADDR, {9'h000, a}, st);
        bus(1'b1, spcd_pkg::REG_WDATA, {24'h000000, d}, st);
        bus(1'b1, spcd_pkg::REG_CTRL, {29'h00000000, c}, st);
        n = 0;
        do begin bus(1'b0, spcd_pkg::REG_STATUS, 32'h00000000, st); n++; end
        while (st[spcd_pkg::ST_DONE] !== 1'b1 && n < 400);
        `CHK("op done", 1'b1, st[spcd_pkg::ST_DONE])
    endtask : op
    task automatic t_reset;
        `CHK("ce idle", 1'b1, fl_ce_n)
        `CHK("dq idle", 1'b0, fl_dq_oe)
        `CHK("hresp", 1'b0, hresp)
        bus(1'b0, spcd_pkg::REG_STATUS, 32'h00000000, st);
        `CHK("status rst", 32'h00000000, st)
        bus(1'b1, 3'h7, 32'hFFFFFFFF, st);
        bus(1'b0, 3'h7, 32'h00000000, st);
        `CHK("unmapped", 32'h00000000, st)
        $display("test reset done");
    endtask : t_reset
    task automatic t_lock;
        op(spcd_pkg::OP_ENTER, 23'h000000, 8'h40);
        `CHK("lock entry", 8'h40, m_mode)
        `CHK("mode field", 8'h40, st[23:16])
        op(spcd_pkg::OP_PROG, 23'h000000, 8'h5A);
        op(spcd_pkg::OP_READ, 23'h000000, 8'h00);
        `CHK("lock read", 8'h5A, st[15:8])
        op(spcd_pkg::OP_EXIT, 23'h000000, 8'h00);
        `CHK("exit mode", 8'h00, m_mode)
        $display("test lock done");
    endtask : t_lock
    task automatic t_pwd;
        pw = 64'h1E2D3C4B5A697887;
        op(spcd_pkg::OP_ENTER, 23'h000000, 8'h60);
        for (int i = 0; i < 8; i++) op(spcd_pkg::OP_PROG, 23'(i), pw[8*i+:8]);
        for (int i = 0; i < 8; i++) begin
            op(spcd_pkg::OP_READ, 23'(i), 8'h00);
            `CHK("pwd byte", pw[8*i+:8], st[15:8])
        end
        bus(1'b1, spcd_pkg::REG_PWD_LO, pw[31:0], st);
        bus(1'b1, spcd_pkg::REG_PWD_HI, pw[63:32], st);
        bus(1'b0, spcd_pkg::REG_PWD_LO, 32'h00000000, st);
        `CHK("pwd lo reg", pw[31:0], st)
        op(spcd_pkg::OP_UNLOCK, 23'h000000, 8'h00);
        `CHK("unlock ok", 1'b1, m_unl)
        bus(1'b1, spcd_pkg::REG_PWD_HI, 32'h11111111, st);
        op(spcd_pkg::OP_UNLOCK, 23'h000000, 8'h00);
        `CHK("unlock bad", 1'b0, m_unl)
        op(spcd_pkg::OP_RESET, 23'h000000, 8'h00);
        `CHK("reset mode", 8'h00, m_mode)
        $display("test password done");
    endtask : t_pwd
    task automatic t_ppb;
        op(spcd_pkg::OP_ENTER, 23'h000000, 8'hC0);
        op(spcd_pkg::OP_PROG, 23'h030123, 8'h00);
        `CHK("accel", 0, m_acc)
        op(spcd_pkg::OP_READ, 23'h03FFFF, 8'h00);
        `CHK("ppb set", 1'b0, st[8])
        op(spcd_pkg::OP_READ, 23'h040000, 8'h00);
        `CHK("ppb other", 1'b1, st[8])
        op(spcd_pkg::OP_ERASE, 23'h000000, 8'h00);
        op(spcd_pkg::OP_READ, 23'h030000, 8'h00);
        `CHK("ppb erased", 1'b1, st[8])
        op(spcd_pkg::OP_EXIT, 23'h000000, 8'h00);
        $display("test persistent done");
    endtask : t_ppb
    task automatic t_frz;
        op(spcd_pkg::OP_ENTER, 23'h7FF000, 8'h50);
        op(spcd_pkg::OP_READ, 23'h000000, 8'h00);
        `CHK("freeze clr", 1'b1, st[8])
        op(spcd_pkg::OP_PROG, 23'h000000, 8'h00);
        op(spcd_pkg::OP_READ, 23'h000123, 8'h00);
        `CHK("freeze set", 1'b0, st[8])
        op(spcd_pkg::OP_RESET, 23'h000000, 8'h00);
        $display("test freeze done");
    endtask : t_frz
    task automatic t_dyb;
        op(spcd_pkg::OP_ENTER, 23'h000000, 8'hE0);
        op(spcd_pkg::OP_PROG, 23'h050000, 8'h00);
        op(spcd_pkg::OP_READ, 23'h050010, 8'h00);
        `CHK("dyb set", 1'b0, st[8])
        op(spcd_pkg::OP_PROG, 23'h050000, 8'h01);
        op(spcd_pkg::OP_READ, 23'h050000, 8'h00);
        `CHK("dyb clr", 1'b1, st[8])
        `CHK("accel", 0, m_acc)
        op(spcd_pkg::OP_EXIT, 23'h000000, 8'h00);
        $display("test volatile done");
    endtask : t_dyb
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h00000000; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h00000000; bad_count = 0; total_checks = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_lock();
        t_pwd();
        t_ppb();
        t_frz();
        t_dyb();
        print_verdict();
    end
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
endmodule : tb_sector_protect_cmd_decoder
`default_nettype wire
